// File: hdl/dbs_buf2.sv
`timescale 1ns/1ps
`default_nettype none

// Two-entry buffer; the head entry feeds the output straight from a flop.
module dbs_buf2 #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] head_reg;
  logic [W-1:0] tail_reg;
  logic head_full_reg;
  logic tail_full_reg;
  logic push;
  logic pop;

  // Full only when both entries hold a word.
  assign in_ready = ~tail_full_reg;
  assign out_valid = head_full_reg;
  assign out_data = head_reg;
  assign push = in_valid & ~tail_full_reg;
  assign pop = head_full_reg & out_ready;

  // Occupancy flags.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      head_full_reg <= 1'b0;
      tail_full_reg <= 1'b0;
    end else begin
      head_full_reg <= tail_full_reg | push | (head_full_reg & ~pop);
      tail_full_reg <= head_full_reg & (tail_full_reg | push) &
                       ~(pop & ~(tail_full_reg & push)) &
                       ~(pop & ~tail_full_reg);
    end
  end

  // Data moves from tail to head on a pop; new words fill the free slot.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      head_reg <= '0;
      tail_reg <= '0;
    end else begin
      if (pop) begin
        head_reg <= tail_full_reg ? tail_reg : in_data;
      end else if (!head_full_reg) begin
        head_reg <= in_data;
      end
      if (push && head_full_reg && (tail_full_reg || !pop)) begin
        tail_reg <= in_data;
      end
    end
  end

endmodule

`default_nettype wire

// File: hdl/dbs_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Memory controller end: one burst command at a time.
module dbs_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  dbs_link_if.ctl link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [dbs_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [dbs_pkg::BURST_W-1:0] cmd_wdata,
  input wire logic [dbs_pkg::LANES*dbs_pkg::BURST_LEN-1:0] cmd_lane_n,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [dbs_pkg::BURST_W-1:0] rd_data,
  input wire logic stop_req,
  output logic stopped
);

  localparam int DW = dbs_pkg::DATA_W;
  localparam int LN = dbs_pkg::LANES;

  logic k_run_reg;
  logic k_true_reg;
  logic read_n_reg;
  logic write_n_reg;
  logic [dbs_pkg::ADDR_W-1:0] addr_reg;
  logic [DW-1:0] d_reg;
  logic [LN-1:0] lane_n_reg;
  dbs_pkg::dbs_op_type op_reg;
  logic [3:0] cnt_reg;
  logic [dbs_pkg::BURST_W-1:0] wbuf_reg;
  logic [LN*dbs_pkg::BURST_LEN-1:0] wlane_reg;
  logic [dbs_pkg::BURST_W-1:0] rbuf_reg;
  logic push_reg;
  logic take;
  logic buf_in_ready;
  logic [1:0] wr_idx;
  logic [1:0] rd_idx;

  assign take = cmd_valid & cmd_ready;
  assign wr_idx = 2'(cnt_reg - dbs_pkg::WR_FIRST);
  assign rd_idx = 2'(cnt_reg - dbs_pkg::RD_FIRST);

  // Clock generation; the clock only stops once all bursts are done.
  // It never stops on a taking edge, or a command would freeze half sent.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      k_run_reg <= 1'b1;
      k_true_reg <= 1'b1;
    end else begin
      if (k_run_reg) begin
        k_true_reg <= ~k_true_reg;
      end
      if (stop_req && op_reg == dbs_pkg::DBS_OP_IDLE && !push_reg &&
          !take) begin
        k_run_reg <= 1'b0;
      end else if (!stop_req) begin
        k_run_reg <= 1'b1;
      end
    end
  end

  // Ready only ahead of a true edge, idle, and with room for read data.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ready <= 1'b0;
    end else begin
      cmd_ready <= ~k_true_reg & k_run_reg & ~stop_req & ~push_reg &
                   (cnt_reg == dbs_pkg::CNT_ZERO) & ~take & buf_in_ready;
    end
  end

  // Selects are held for one full cycle and then released.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_n_reg <= 1'b1;
      write_n_reg <= 1'b1;
      addr_reg <= '0;
      wbuf_reg <= '0;
      wlane_reg <= '1;
    end else if (take) begin
      read_n_reg <= cmd_write;
      write_n_reg <= ~cmd_write;
      addr_reg <= cmd_addr;
      wbuf_reg <= cmd_wdata;
      wlane_reg <= cmd_lane_n;
    end else if (k_run_reg && k_true_reg) begin
      read_n_reg <= 1'b1;
      write_n_reg <= 1'b1;
    end
  end

  // Beat sequencing counted from the launching edge.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_reg <= dbs_pkg::DBS_OP_IDLE;
      cnt_reg <= dbs_pkg::CNT_ZERO;
      d_reg <= '0;
      lane_n_reg <= dbs_pkg::LANES_OFF;
      rbuf_reg <= '0;
      push_reg <= 1'b0;
    end else begin
      push_reg <= 1'b0;
      unique case (op_reg)
        dbs_pkg::DBS_OP_IDLE: begin
          if (take) begin
            op_reg <= cmd_write ? dbs_pkg::DBS_OP_WRITE : dbs_pkg::DBS_OP_READ;
            cnt_reg <= dbs_pkg::CNT_ONE;
          end
        end
        dbs_pkg::DBS_OP_WRITE: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == dbs_pkg::WR_LAST) begin
            op_reg <= dbs_pkg::DBS_OP_IDLE;
            cnt_reg <= dbs_pkg::CNT_ZERO;
            lane_n_reg <= dbs_pkg::LANES_OFF;
          end else if (cnt_reg >= dbs_pkg::WR_FIRST) begin
            d_reg <= wbuf_reg[wr_idx*DW +: DW];
            lane_n_reg <= wlane_reg[wr_idx*LN +: LN];
          end
        end
        dbs_pkg::DBS_OP_READ: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg >= dbs_pkg::RD_FIRST) begin
            rbuf_reg[rd_idx*DW +: DW] <= link.q;
          end
          if (cnt_reg == dbs_pkg::RD_LAST) begin
            op_reg <= dbs_pkg::DBS_OP_IDLE;
            cnt_reg <= dbs_pkg::CNT_ZERO;
            push_reg <= 1'b1;
          end
        end
        default: begin
          op_reg <= dbs_pkg::DBS_OP_IDLE;
          cnt_reg <= dbs_pkg::CNT_ZERO;
        end
      endcase
    end
  end

  // Whole read bursts wait here until the user side takes them.
  dbs_buf2 #(
    .W(dbs_pkg::BURST_W)
  ) u_rd_buf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(push_reg),
    .in_ready(buf_in_ready),
    .in_data(rbuf_reg),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  assign stopped = ~k_run_reg;
  assign link.k_run = k_run_reg;
  assign link.k_true = k_true_reg;
  assign link.read_n = read_n_reg;
  assign link.write_n = write_n_reg;
  assign link.addr = addr_reg;
  assign link.d = d_reg;
  assign link.lane_write_n = lane_n_reg;

endmodule

`default_nettype wire

// File: hdl/dbs_device.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module dbs_device (
  input wire logic ref_clk,
  input wire logic rst_n,
  dbs_link_if.dev link,
  output logic rd_busy,
  output logic wr_busy
);

  localparam int RDL = dbs_pkg::RD_LAT_HALVES;
  localparam int WRL = dbs_pkg::WR_LAT_HALVES;

  logic [dbs_pkg::DATA_W-1:0] mem_array [0:dbs_pkg::MEM_DEPTH-1];

  logic adv;
  logic true_edge;
  logic rd_take;
  logic wr_take;
  logic rd_last_reg;
  logic wr_last_reg;
  logic prev_nop_reg;
  logic [RDL-1:0] rd_tok_reg;
  logic [dbs_pkg::ADDR_W-1:0] rd_pipe_reg [0:RDL-1];
  logic [WRL-1:0] wr_tok_reg;
  logic [dbs_pkg::ADDR_W-1:0] wr_pipe_reg [0:WRL-1];
  dbs_pkg::dbs_burst_type rd_state_reg;
  dbs_pkg::dbs_burst_type wr_state_reg;
  logic [1:0] rd_beat_reg;
  logic [1:0] wr_beat_reg;
  logic [dbs_pkg::ADDR_W-1:0] rd_ptr_reg;
  logic [dbs_pkg::ADDR_W-1:0] wr_ptr_reg;
  logic [dbs_pkg::ADDR_W-1:0] rd_addr;
  logic [dbs_pkg::ADDR_W-1:0] wr_addr;
  logic rd_beat;
  logic wr_beat;
  logic [dbs_pkg::DATA_W-1:0] wr_merge;
  logic [dbs_pkg::DATA_W-1:0] q_reg;
  logic q_oe_reg;

  ////////////////////////////////////////////////////////////////////////
  // Command decode on true edges.

  // Nothing moves while the controller holds the clock stopped.
  assign adv = link.k_run;
  assign true_edge = adv & link.k_true;
  // A read right after an accepted read is dropped.
  assign rd_take = true_edge & ~link.read_n & ~rd_last_reg;
  // Write is dropped after an accepted write, or if it collides after idle.
  assign wr_take = true_edge & ~link.write_n & ~wr_last_reg &
                   ~(rd_take & prev_nop_reg);

  // Acceptance history, kept per true edge only.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_last_reg <= 1'b0;
      wr_last_reg <= 1'b0;
      prev_nop_reg <= 1'b1;
    end else if (true_edge) begin
      rd_last_reg <= rd_take;
      wr_last_reg <= wr_take;
      prev_nop_reg <= link.read_n & link.write_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Latency lines carry each accepted command to its first beat.

  // Tokens and addresses shift by one half cycle per running edge.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_tok_reg <= '0;
      wr_tok_reg <= '0;
      for (int i = 0; i < RDL; i++) begin
        rd_pipe_reg[i] <= '0;
      end
      for (int i = 0; i < WRL; i++) begin
        wr_pipe_reg[i] <= '0;
      end
    end else if (adv) begin
      rd_tok_reg <= {rd_tok_reg[RDL-2:0], rd_take};
      wr_tok_reg <= {wr_tok_reg[WRL-2:0], wr_take};
      rd_pipe_reg[0] <= link.addr;
      wr_pipe_reg[0] <= link.addr;
      for (int i = 1; i < RDL; i++) begin
        rd_pipe_reg[i] <= rd_pipe_reg[i-1];
      end
      for (int i = 1; i < WRL; i++) begin
        wr_pipe_reg[i] <= wr_pipe_reg[i-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read burst machine.

  assign rd_beat = rd_tok_reg[RDL-1] | (rd_state_reg == dbs_pkg::DBS_BURST);
  assign rd_addr = rd_tok_reg[RDL-1] ? rd_pipe_reg[RDL-1] : rd_ptr_reg;

  // Four beats from the start address upward, one per half cycle.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_state_reg <= dbs_pkg::DBS_IDLE;
      rd_beat_reg <= 2'h0;
      rd_ptr_reg <= '0;
    end else if (adv) begin
      if (rd_tok_reg[RDL-1]) begin
        rd_state_reg <= dbs_pkg::DBS_BURST;
        rd_beat_reg <= 2'h1;
        rd_ptr_reg <= rd_addr + 1'b1;
      end else if (rd_state_reg == dbs_pkg::DBS_BURST) begin
        rd_beat_reg <= rd_beat_reg + 1'b1;
        rd_ptr_reg <= rd_addr + 1'b1;
        if (rd_beat_reg == dbs_pkg::BEAT_LAST) begin
          rd_state_reg <= dbs_pkg::DBS_IDLE;
        end
      end
    end
  end

  // Output beats launch on their edge; empty slots release the pins.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg <= '0;
      q_oe_reg <= 1'b0;
    end else if (adv) begin
      q_oe_reg <= rd_beat;
      if (rd_beat) begin
        q_reg <= mem_array[rd_addr];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write burst machine.

  assign wr_beat = wr_tok_reg[WRL-1] | (wr_state_reg == dbs_pkg::DBS_BURST);
  assign wr_addr = wr_tok_reg[WRL-1] ? wr_pipe_reg[WRL-1] : wr_ptr_reg;

  // Four captured beats go to ascending addresses.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_state_reg <= dbs_pkg::DBS_IDLE;
      wr_beat_reg <= 2'h0;
      wr_ptr_reg <= '0;
    end else if (adv) begin
      if (wr_tok_reg[WRL-1]) begin
        wr_state_reg <= dbs_pkg::DBS_BURST;
        wr_beat_reg <= 2'h1;
        wr_ptr_reg <= wr_addr + 1'b1;
      end else if (wr_state_reg == dbs_pkg::DBS_BURST) begin
        wr_beat_reg <= wr_beat_reg + 1'b1;
        wr_ptr_reg <= wr_addr + 1'b1;
        if (wr_beat_reg == dbs_pkg::BEAT_LAST) begin
          wr_state_reg <= dbs_pkg::DBS_IDLE;
        end
      end
    end
  end

  // Each lane takes new data only when its enable is low.
  for (genvar g = 0; g < dbs_pkg::LANES; g++) begin : g_lane
    assign wr_merge[g*dbs_pkg::LANE_W +: dbs_pkg::LANE_W] =
      link.lane_write_n[g] ?
      mem_array[wr_addr][g*dbs_pkg::LANE_W +: dbs_pkg::LANE_W] :
      link.d[g*dbs_pkg::LANE_W +: dbs_pkg::LANE_W];
  end

  // Array update; a beat with every lane high is an abort and is skipped.
  always_ff @(posedge ref_clk) begin
    if (adv && wr_beat && (link.lane_write_n != dbs_pkg::LANES_OFF)) begin
      mem_array[wr_addr] <= wr_merge;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Busy flags report a command in flight or bursting.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_busy <= 1'b0;
      wr_busy <= 1'b0;
    end else begin
      rd_busy <= (|rd_tok_reg) | (rd_state_reg == dbs_pkg::DBS_BURST);
      wr_busy <= (|wr_tok_reg) | (wr_state_reg == dbs_pkg::DBS_BURST);
    end
  end

  assign link.q = q_reg;
  assign link.q_oe = q_oe_reg;

endmodule

`default_nettype wire

// File: hdl/dbs_link_if.sv
`timescale 1ns/1ps
`default_nettype none

// Pins between the memory controller and the burst memory.
interface dbs_link_if;
  logic k_run;
  logic k_true;
  logic read_n;
  logic write_n;
  logic [dbs_pkg::ADDR_W-1:0] addr;
  logic [dbs_pkg::DATA_W-1:0] d;
  logic [dbs_pkg::LANES-1:0] lane_write_n;
  logic [dbs_pkg::DATA_W-1:0] q;
  logic q_oe;

  modport dev (
    input k_run, k_true, read_n, write_n, addr, d, lane_write_n,
    output q, q_oe
  );

  modport ctl (
    output k_run, k_true, read_n, write_n, addr, d, lane_write_n,
    input q, q_oe
  );
endinterface

`default_nettype wire

// File: hdl/dbs_pkg.sv
package dbs_pkg;

  // Array and bus widths of the 36-bit configuration.
  localparam int ADDR_W = 19;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int DATA_W = LANE_W * LANES;
  localparam int BURST_LEN = 4;
  localparam int BURST_W = DATA_W * BURST_LEN;
  localparam int MEM_DEPTH = 1 << ADDR_W;

  // Half-cycle latencies on the device side, counted in ref_clk edges.
  localparam int RD_LAT_HALVES = 5;
  localparam int WR_LAT_HALVES = 2;

  // Controller sequencing counts from the edge that launches a command.
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] WR_FIRST = 4'h3;
  localparam logic [3:0] WR_LAST = 4'h7;
  localparam logic [3:0] RD_FIRST = 4'h8;
  localparam logic [3:0] RD_LAST = 4'hB;
  localparam logic [1:0] BEAT_LAST = 2'h3;
  localparam logic [LANES-1:0] LANES_OFF = 4'hF;

  // Device burst state machines.
  typedef enum logic {
    DBS_IDLE = 1'b0,
    DBS_BURST = 1'b1
  } dbs_burst_type;

  // Controller operation in progress.
  typedef enum logic [1:0] {
    DBS_OP_IDLE = 2'b00,
    DBS_OP_READ = 2'b01,
    DBS_OP_WRITE = 2'b10
  } dbs_op_type;

endpackage

// File: test/dbs_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// Checks the link between the controller and the burst memory.
module dbs_link_asserts (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic k_run,
  input wire logic k_true,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic [dbs_pkg::LANES-1:0] lane_write_n,
  input wire logic [dbs_pkg::DATA_W-1:0] q,
  input wire logic q_oe
);
  logic rd_acc;
  logic wr_acc;
  logic lanes_off;

  // Commands taken at a true edge, and a beat that writes nothing.
  assign rd_acc = !read_n && k_true && k_run;
  assign wr_acc = !write_n && k_true && k_run;
  assign lanes_off = lane_write_n == dbs_pkg::LANES_OFF;

  // One clock domain; the checks pause in reset.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////
  property p_rd_lat;
    rd_acc |-> ##6 q_oe [*4];
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read beats off");
  property p_oe_end;
    $rose(q_oe) |-> q_oe [*4] ##1 (!q_oe || $past(rd_acc, 6));
  endproperty
  a_oe_end: assert property (p_oe_end) else $error("output not off");
  property p_gap;
    rd_acc || wr_acc |-> ##2 !rd_acc && !wr_acc;
  endproperty
  a_gap: assert property (p_gap) else $error("commands too close");
  property p_wr_beats;
    wr_acc |-> ##2 k_true ##1 !k_true ##1 k_true ##1 !k_true ##1 lanes_off;
  endproperty
  a_wr_beats: assert property (p_wr_beats) else $error("write beats off");
  property p_lane_src;
    !lanes_off |-> $past(wr_acc, 2) || $past(wr_acc, 3) ||
      $past(wr_acc, 4) || $past(wr_acc, 5);
  endproperty
  a_lane_src: assert property (p_lane_src) else $error("stray lanes");
  property p_true_alt;
    k_run && $past(k_run) && $past(rst_n) |-> k_true != $past(k_true);
  endproperty
  a_true_alt: assert property (p_true_alt) else $error("edge mark off");
  property p_freeze;
    !k_run |=> $stable(q) && $stable(q_oe);
  endproperty
  a_freeze: assert property (p_freeze) else $error("output moved");
  property p_stop_idle;
    !k_run |-> read_n && write_n && !q_oe && lanes_off;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("busy stop");

  // Main traffic kinds and a clock restart.
  c_read: cover property (rd_acc);
  c_write: cover property (wr_acc);
  c_stop: cover property (!k_run ##1 k_run);
endmodule

`default_nettype wire

// File: test/ddr_burst4_sram_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// Joins both ends on one link and drives a second memory directly.
module ddr_burst4_sram_core_tb_top;
  logic ref_clk, rst_n, cmd_valid, cmd_ready, cmd_write, rd_valid;
  logic rd_ready, stop_req, stopped, l2_rd_busy, l2_wr_busy;
  logic [dbs_pkg::ADDR_W-1:0] cmd_addr;
  logic [143:0] cmd_wdata, rd_data;
  logic [15:0] cmd_lane_n;
  int error_cnt, compares, cyc;

  dbs_link_if link ();
  dbs_link_if l2 ();
  // Both ends share the first link; the second memory faces the bench.
  dbs_device dbs_device_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(link.dev), .rd_busy(), .wr_busy());
  dbs_device dbs_device_inst2 (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(l2.dev), .rd_busy(l2_rd_busy), .wr_busy(l2_wr_busy));
  dbs_ctrl dbs_ctrl_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link.ctl),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_lane_n(cmd_lane_n),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .stop_req(stop_req), .stopped(stopped));
  dbs_link_asserts dbs_link_asserts_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .k_run(link.k_run), .k_true(link.k_true), .read_n(link.read_n),
    .write_n(link.write_n), .lane_write_n(link.lane_write_n),
    .q(link.q), .q_oe(link.q_oe));

  // Clock with a 5 ns period.
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Marks true edges on the second link; it stands at one in reset.
  always @(negedge ref_clk) begin
    l2.k_true <= rst_n ? ~l2.k_true : 1'b1;
  end

  // Cuts a hung run short.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  ////////////////////////////////////////
  // Compares one value with its expectation.
  task automatic chk(input string nm, input logic [143:0] s, e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Prints the counts and the verdict.
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Builds a burst that counts up from a base word.
  function automatic logic [143:0] bw(input logic [35:0] b);
    return {b + 36'h3, b + 36'h2, b + 36'h1, b};
  endfunction

  // Applies new data to the lanes whose enable is low.
  function automatic logic [143:0] mrg(input logic [143:0] o, n,
                                       input logic [15:0] ln);
    mrg = o;
    for (int i = 0; i < 16; i++) begin
      if (!ln[i]) mrg[i*9 +: 9] = n[i*9 +: 9];
    end
  endfunction

  // Offers one command and holds it until it is taken.
  task automatic op(input logic w, input logic [18:0] a,
                    input logic [143:0] wd, input logic [15:0] ln);
    int n;
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= wd;
    cmd_lane_n <= ln;
    for (n = 0; n < 200 && cmd_ready !== 1'b1; n++) @(negedge ref_clk);
    @(negedge ref_clk);
    cmd_valid <= 1'b0;
    // Lets an edge pass so that a following offer never lands in this step.
    @(negedge ref_clk);
  endtask

  // Waits for a read burst and checks it.
  task automatic rsp(input logic [143:0] e);
    int n;
    for (n = 0; n < 200 && rd_valid !== 1'b1; n++) @(negedge ref_clk);
    chk("rd_valid", 144'(rd_valid), 144'h1);
    chk("rd_data", rd_data, e);
    @(negedge ref_clk);
  endtask

  // Raw link: selects at a true edge t and at t plus two,
  // six data beats from t plus two, and read beats checked if a read came first.
  task automatic l2op(input logic r1, w1, r2, w2, input logic [18:0] a,
                      input logic [35:0] wd, rq, input logic [1:0] bz);
    @(posedge ref_clk);
    while (l2.k_true !== 1'b0) @(posedge ref_clk);
    @(negedge ref_clk);
    l2.read_n <= r1;
    l2.write_n <= w1;
    l2.addr <= a;
    for (int j = 1; j <= 10; j++) begin
      @(negedge ref_clk);
      if (j == 1) begin
        l2.read_n <= r2;
        l2.write_n <= w2;
        l2.addr <= a + 19'h0_0008;
      end
      if (j == 3) begin
        l2.read_n <= 1'b1;
        l2.write_n <= 1'b1;
      end
      l2.d <= wd + 36'(j);
      l2.lane_write_n <= (j >= 2 && j <= 7) ? 4'h0 : 4'hF;
      if (j == 5) begin
        chk("l2_busy", 144'({l2_rd_busy, l2_wr_busy}), 144'(bz));
      end
      if (!r1 && j >= 6 && j <= 9) begin
        chk("l2_q", {l2.q_oe, l2.q}, {1'b1, rq + 36'(j - 6)});
      end
      if (!r1 && j == 10) chk("l2_q_oe", 144'(l2.q_oe), 144'h0);
    end
  endtask

  ////////////////////////////////////////
  // Full bursts at a plain and at the highest aligned address.
  task automatic sc_burst();
    op(1'b1, 19'h0_0100, bw(36'h1_0000_0000), 16'h0000);
    op(1'b0, 19'h0_0100, '0, 16'hFFFF);
    rsp(bw(36'h1_0000_0000));
    op(1'b1, 19'h7_FFFC, bw(36'h2_0000_0000), 16'h0000);
    op(1'b0, 19'h7_FFFC, '0, 16'hFFFF);
    rsp(bw(36'h2_0000_0000));
  endtask

  // Per-beat lane masks: each of four lanes, then single lanes, one two-lane beat and an empty beat.
  task automatic sc_lanes();
    logic [143:0] m;
    m = mrg(bw(36'h1_0000_0000), {4{36'hA_AAAA_AAAA}}, 16'h7BDE);
    op(1'b1, 19'h0_0100, {4{36'hA_AAAA_AAAA}}, 16'h7BDE);
    op(1'b0, 19'h0_0100, '0, 16'hFFFF);
    rsp(m);
    op(1'b1, 19'h0_0100, {4{36'h5_5555_5555}}, 16'hFCDE);
    op(1'b0, 19'h0_0100, '0, 16'hFFFF);
    rsp(mrg(m, {4{36'h5_5555_5555}}, 16'hFCDE));
  endtask

  // Two unread bursts fill the buffer, so a third command must wait.
  task automatic sc_stall();
    int hits;
    hits = 0;
    rd_ready <= 1'b0;
    op(1'b0, 19'h7_FFFC, '0, 16'hFFFF);
    op(1'b0, 19'h7_FFFC, '0, 16'hFFFF);
    cmd_valid <= 1'b1;
    repeat (40) begin
      @(negedge ref_clk);
      hits += int'(cmd_ready === 1'b1);
    end
    chk("cmd_ready", 144'(hits), 144'h0);
    cmd_valid <= 1'b0;
    rd_ready <= 1'b1;
    rsp(bw(36'h2_0000_0000));
    rsp(bw(36'h2_0000_0000));
    chk("rd_valid", 144'(rd_valid), 144'h0);
  endtask

  // Clock stop while idle keeps the stored data.
  task automatic sc_stop();
    stop_req <= 1'b1;
    for (int n = 0; n < 100 && stopped !== 1'b1; n++) @(negedge ref_clk);
    repeat (10) @(negedge ref_clk);
    chk("stopped", 144'({stopped, link.k_run}), 144'h2);
    stop_req <= 1'b0;
    repeat (4) @(negedge ref_clk);
    op(1'b0, 19'h7_FFFC, '0, 16'hFFFF);
    rsp(bw(36'h2_0000_0000));
  endtask

  // Commands that break the spacing and select rules on the raw link.
  task automatic sc_link2();
    l2op(1'b1, 1'b0, 1'b1, 1'b1, 19'h0_0048, 36'h0_0000_0200, '0,
         2'h1);
    l2op(1'b1, 1'b0, 1'b1, 1'b0, 19'h0_0040, 36'h0_0000_0100, '0,
         2'h1);
    l2op(1'b0, 1'b1, 1'b1, 1'b1, 19'h0_0048, '0, 36'h0_0000_0202,
         2'h2);
    l2op(1'b0, 1'b1, 1'b1, 1'b1, 19'h0_0040, '0, 36'h0_0000_0102,
         2'h2);
    l2op(1'b0, 1'b0, 1'b1, 1'b1, 19'h0_0040, 36'h0_0000_0300,
         36'h0_0000_0102, 2'h2);
    l2op(1'b0, 1'b1, 1'b0, 1'b1, 19'h0_0040, '0, 36'h0_0000_0102,
         2'h2);
    l2op(1'b0, 1'b1, 1'b1, 1'b0, 19'h0_0040, 36'h0_0000_0400,
         36'h0_0000_0102, 2'h3);
    l2op(1'b0, 1'b1, 1'b1, 1'b1, 19'h0_0048, '0, 36'h0_0000_0404,
         2'h2);
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    {rst_n, cmd_valid, cmd_write, stop_req} = 4'h0;
    {cmd_addr, cmd_wdata, cmd_lane_n} = '1;
    {error_cnt, compares, cyc} = '0;
    rd_ready = 1'b1;
    {l2.k_run, l2.read_n, l2.write_n} = 3'h7;
    {l2.addr, l2.d} = '0;
    l2.lane_write_n = 4'hF;
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    sc_burst();
    sc_lanes();
    sc_stall();
    sc_stop();
    sc_link2();
    end_of_test();
  end
endmodule

`default_nettype wire
